// file: design/ebm_consts.vh
// Constants for the eSPI bus monitor: register map, fields, codes and reset values.
`ifndef EBM_CONSTS_VH
`define EBM_CONSTS_VH
`define EBM_REG_CTRL 6'h00
`define EBM_REG_STATUS 6'h01
`define EBM_REG_SMATCH 6'h02
`define EBM_REG_ADV 6'h03
`define EBM_REG_ADVCMD 6'h04
`define EBM_REG_FILT0 6'h05
`define EBM_REG_FILT1 6'h06
`define EBM_REG_DIODIR 6'h07
`define EBM_REG_DIOMODE 6'h08
`define EBM_REG_STATSEL 6'h09
`define EBM_REG_STATDAT 6'h0A
`define EBM_REG_CHCAP0 6'h0C
`define EBM_CTRL_RST 32'h00000000
`define EBM_IO_SINGLE 2'h0
`define EBM_IO_DUAL 2'h1
`define EBM_FRQ_20 3'h0
`define EBM_MSEL_SIMPLE 2'h1
`define EBM_MSEL_ADV 2'h2
`define EBM_ADV_MULTI 2'h0
`define EBM_ADV_NP 2'h1
`define EBM_ADV_ERR 2'h2
`define EBM_OP_GET_CFG 8'h21
`define EBM_OP_SET_CFG 8'h22
`define EBM_OP_GET_STS 8'h25
`define EBM_OP_RESET 8'hFF
`define EBM_GEN_CAP_ADDR 16'h0008
`define EBM_GC_FRQ_LSB 20
`define EBM_GC_IO_LSB 26
`define EBM_GC_ALERT_BIT 28
`define EBM_RSP_NONFATAL 6'h02
`define EBM_RSP_FATAL 6'h03
`define EBM_CPL_MIDDLE 2'h0
`define EBM_CPL_FIRST 2'h1
`define EBM_CRC_POLY 8'h07
`define EBM_TAR_CLKS 2'h2
`define EBM_NCNT 12
`define EBM_REC_PKT 4'h1
`define EBM_REC_DIO 4'h2
`endif

// file: design/ebm_rec_ram.v
// Record memory for the capture buffer, with registered read data.
`timescale 1ns/1ps
module ebm_rec_ram #(
    parameter AW = 10,
    parameter DW = 32
) (
    // Clock
    input wire clk,
    // Write port
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    // Read port
    input wire re,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule // ebm_rec_ram

// file: design/ebm_monitor.v
// Passive eSPI bus monitor with triggers, filters, statistics and user pins.
// Notes on behaviour
// - Decode all rates in single, dual, quad width.
// - Enabled user input change inserts event record.
// - Power-up assumes single IO at 20 MHz.
// - Configuration write latches IO, alert, frequency.
// - Software may force IO width and alert.
// - Standard mode streams records out at once.
// - Delayed mode holds records until monitoring stops.
// - Remember channel capability configuration writes.
// - Check command and response CRC separately.
// - Bus reset toggle restores default IO, frequency.
// - User outputs: low, high, toggle from low/high.
// - Simple match triggers on selected packet events.
// - Simple and advanced match never both active.
// - Trigger fires once, earliest event wins.
// - Simple match output toggled once at trigger.
// - Advanced sequence of up to four levels.
// - Advanced tracking of non-posted request completions.
// - Advanced match triggers on error response.
// - Per-slave filters drop packets before host.
// - Per-slave statistics counters.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ebm_consts.vh"
module ebm_monitor #(
    parameter NDIO = 11,
    parameter BUF_AW = 10
) (
    // System
    input wire clk,
    input wire reset,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Monitored eSPI lines
    input wire espi_sck,
    input wire [1:0] espi_cs_n,
    input wire [3:0] espi_io,
    input wire alert_pin_first,
    input wire alert_pin_second,
    input wire bus_reset_first_n,
    input wire bus_reset_second_n,
    // User digital pins
    input wire [NDIO-1:0] user_digital_pin_i,
    output wire [NDIO-1:0] user_digital_pin_o,
    output wire [NDIO-1:0] user_digital_pin_oe_n,
    // Capture record stream
    output wire rec_valid,
    output wire [31:0] rec_data,
    input wire rec_ready
);
    localparam SW = 11 + NDIO;
    localparam ST_IDLE = 4'b0001;
    localparam ST_CMD = 4'b0010;
    localparam ST_TAR = 4'b0100;
    localparam ST_RSP = 4'b1000;

    function [7:0] crc8;
        input [7:0] c;
        input [7:0] d;
        integer i;
        reg [7:0] x;
        begin
            x = c ^ d;
            for (i = 0; i < 8; i = i + 1) begin
                x = x[7] ? ({x[6:0], 1'b0} ^ `EBM_CRC_POLY) : {x[6:0], 1'b0};
            end
            crc8 = x;
        end
    endfunction

    // Channel as one-hot {indep, flash, oob, vwire, periph}.
    function [4:0] chan;
        input [7:0] op;
        begin
            if (op[7:4] == 4'h4 || op[7:2] == 6'h00) begin
                chan = 5'h01;
            end else if (op[7:1] == 7'h02) begin
                chan = 5'h02;
            end else if (op[7:1] == 7'h03) begin
                chan = 5'h04;
            end else if (op[7:1] == 7'h04) begin
                chan = 5'h08;
            end else begin
                chan = 5'h10;
            end
        end
    endfunction

    // Command bytes before the command CRC.
    function [3:0] cmd_len;
        input [7:0] op;
        begin
            if (op == `EBM_OP_SET_CFG) begin
                cmd_len = 4'h7;
            end else if (op == `EBM_OP_GET_CFG) begin
                cmd_len = 4'h3;
            end else if (op[0] || op == `EBM_OP_GET_STS || op == `EBM_OP_RESET) begin
                cmd_len = 4'h1;
            end else begin
                cmd_len = 4'h4;
            end
        end
    endfunction

    // Synchronisers: sck, cs, io, alerts, resets, user pins.
    reg [SW-1:0] meta_r, sync_r, prev_r;
    wire [SW-1:0] in_bus = {user_digital_pin_i, bus_reset_second_n, bus_reset_first_n,
                            alert_pin_second, alert_pin_first, espi_io, espi_cs_n, espi_sck};

    reg [31:0] ctrl_r, smatch_r, adv_r, advcmd_r, filt0_r, filt1_r, diodir_r, diomode_r;
    reg [4:0] statsel_r;
    reg [31:0] prdata_r;
    reg pready_r, pslverr_r;
    reg [3:0] ph_r, nb_r, rn_r, bc_r;
    reg [1:0] tc_r;
    reg [7:0] sh_r, crc_r, op_r, rsp_op_r, cpl_r, rlast_r, rprev_r;
    reg [15:0] addr_r;
    reg [31:0] cfg_r;
    reg cmd_ok_r, slv_r, fired_r, ovf_r, np_arm_r, np_mid_r;
    reg [3:0] io_r;
    reg [5:0] frq_r;
    reg [1:0] alm_r, lvl_r;
    reg [31:0] chcap_r [0:3];
    reg [15:0] cnt_r [0:2*`EBM_NCNT-1];
    reg [NDIO-1:0] tg_r, dio_o_r, dio_oe_n_r, dio_pend_val_r;
    reg dio_pend_r;
    reg [BUF_AW:0] wp_r, rp_r;
    reg pend_r, rec_valid_r;
    reg [31:0] rec_data_r;
    wire [31:0] ram_q;
    integer k;

    wire sck_rise = sync_r[0] & ~prev_r[0];
    // An unused second select held high never looks active.
    wire [1:0] cs_act = ~sync_r[2:1];
    wire cs_any = |cs_act;
    wire cs_was = |(~prev_r[2:1]);
    wire cs_fall = cs_any & ~cs_was;
    wire cs_rise = ~cs_any & cs_was;
    wire [3:0] io_s = sync_r[6:3];
    wire rst_tog = (sync_r[9] ^ prev_r[9]) | (sync_r[10] ^ prev_r[10]);
    wire [1:0] rst_fall = prev_r[10:9] & ~sync_r[10:9];
    wire [NDIO-1:0] dio_s = sync_r[SW-1:11];

    // Forced settings take precedence over learned ones.
    wire [1:0] io_ovr = ctrl_r[5:4];
    wire [1:0] al_ovr = ctrl_r[7:6];
    wire [1:0] io_eff = (io_ovr != 2'h0) ? (io_ovr - 2'h1) : (slv_r ? io_r[3:2] : io_r[1:0]);
    wire al_pin = (al_ovr != 2'h0) ? al_ovr[1] : alm_r[0];
    wire [2:0] frq_eff = slv_r ? frq_r[5:3] : frq_r[2:0];

    // Bits per clock follow the IO width in use.
    wire [3:0] step = (io_eff == `EBM_IO_SINGLE) ? 4'h1 : (io_eff == `EBM_IO_DUAL) ? 4'h2 : 4'h4;
    wire ser_bit = (ph_r == ST_CMD) ? io_s[0] : io_s[1];
    wire [7:0] sh_nxt = (io_eff == `EBM_IO_SINGLE) ? {sh_r[6:0], ser_bit} :
                        (io_eff == `EBM_IO_DUAL) ? {sh_r[5:0], io_s[1:0]} : {sh_r[3:0], io_s};
    wire byte_done = sck_rise && (ph_r == ST_CMD || ph_r == ST_RSP) && (bc_r + step == 4'h8);

    wire pkt_end = cs_rise && ph_r != ST_IDLE && nb_r != 4'h0;
    wire rsp_ok = (rn_r >= 4'h2) && (rprev_r == rlast_r);
    wire rsp_err = (rsp_op_r[5:0] == `EBM_RSP_NONFATAL) || (rsp_op_r[5:0] == `EBM_RSP_FATAL);
    wire [4:0] ch = chan(op_r);
    wire alert_evt = ~cs_any & (al_pin ? (prev_r[7] & ~sync_r[7]) : (prev_r[4] & ~sync_r[4]));

    // Simple match events.
    wire [8:0] s_ev = {rst_tog, alert_evt, {5{pkt_end}} & ch,
                       pkt_end & (op_r != smatch_r[7:0]), pkt_end & (op_r == smatch_r[7:0])};
    wire s_hit = |(s_ev & smatch_r[16:8]);

    // Per-slave hardware filter.
    wire [31:0] fc = slv_r ? filt1_r : filt0_r;
    wire [6:0] f_ev = {ch, op_r != fc[7:0], op_r == fc[7:0]};
    wire drop = pkt_end & |(f_ev & fc[14:8]);
    wire drop_cmd = pkt_end & |(f_ev[1:0] & fc[9:8]);

    wire [1:0] amode = adv_r[1:0];
    wire [7:0] lvl_cmd = advcmd_r[lvl_r*8 +: 8];
    wire multi_hit = amode == `EBM_ADV_MULTI && pkt_end && op_r == lvl_cmd;
    wire np_req = amode == `EBM_ADV_NP && pkt_end && op_r == advcmd_r[7:0];
    wire np_cpl = amode == `EBM_ADV_NP && np_arm_r && pkt_end && rsp_op_r[7:6] != 2'h0
                  && cpl_r[0] == adv_r[13];
    wire a_hit = (multi_hit && lvl_r == adv_r[3:2])
                 || (np_cpl && cpl_r[2:1] != `EBM_CPL_MIDDLE && cpl_r[2:1] != `EBM_CPL_FIRST)
                 || (amode == `EBM_ADV_ERR && pkt_end && rsp_err);
    reg a_set;
    reg a_val;
    always @* begin
        a_set = 1'b0;
        a_val = 1'b0;
        if (multi_hit) begin
            a_set = 1'b1;
            a_val = adv_r[4 + lvl_r];
        end else if (np_req) begin
            a_set = 1'b1;
            a_val = adv_r[14];
        end else if (np_cpl) begin
            a_set = (cpl_r[2:1] != `EBM_CPL_MIDDLE) || !np_mid_r;
            a_val = (cpl_r[2:1] == `EBM_CPL_FIRST) ? adv_r[15] :
                    (cpl_r[2:1] == `EBM_CPL_MIDDLE) ? adv_r[16] : adv_r[17];
        end
    end

    // One encoded select keeps simple and advanced exclusive; first hit fires once.
    wire msel_s = ctrl_r[3:2] == `EBM_MSEL_SIMPLE;
    wire msel_a = ctrl_r[3:2] == `EBM_MSEL_ADV;
    wire fire = ctrl_r[0] & ~fired_r & ((msel_s & s_hit) | (msel_a & a_hit));
    wire cap_on = ctrl_r[0] & (~(msel_s | msel_a) | fired_r | fire);

    wire [BUF_AW:0] used = wp_r - rp_r;
    wire full = used[BUF_AW];
    wire dio_chg = |((dio_s ^ prev_r[SW-1:11]) & diodir_r[16 +: NDIO] & ~diodir_r[NDIO-1:0]);
    wire pkt_wr = pkt_end & ~drop & cap_on;
    wire dio_wr = ~pkt_wr & dio_pend_r & cap_on;
    wire [31:0] wdat = pkt_wr ? {`EBM_REC_PKT, slv_r, io_eff, frq_eff, cmd_ok_r, rsp_ok, rsp_err,
                                 3'h0, op_r, rsp_op_r}
                              : {`EBM_REC_DIO, 12'h000, {(16-NDIO){1'b0}}, dio_pend_val_r};
    wire we = (pkt_wr | dio_wr) & ~full;
    // Delayed mode drains only once monitoring is off.
    wire drain_ok = ~ctrl_r[1] | ~ctrl_r[0];
    wire re = ~pend_r & ~rec_valid_r & (used != {(BUF_AW+1){1'b0}}) & drain_ok;

    ebm_rec_ram #(.AW(BUF_AW), .DW(32)) i_ebm_rec_ram (
        .clk(clk),
        .we(we),
        .waddr(wp_r[BUF_AW-1:0]),
        .wdata(wdat),
        .re(re),
        .raddr(rp_r[BUF_AW-1:0]),
        .rdata(ram_q)
    );

    // Per-slave statistics increments.
    wire [`EBM_NCNT-1:0] pinc = {drop_cmd, drop, 1'b0, pkt_end & op_r == `EBM_OP_GET_STS,
                                 pkt_end & op_r == `EBM_OP_SET_CFG,
                                 pkt_end & op_r == `EBM_OP_GET_CFG, {4{pkt_end}} & ch[3:0],
                                 pkt_end & ~rsp_ok, pkt_end & ~cmd_ok_r};
    wire [2*`EBM_NCNT-1:0] inc = {(slv_r ? pinc : {`EBM_NCNT{1'b0}}) | {2'h0, rst_fall[1], 9'h000},
                                  (slv_r ? {`EBM_NCNT{1'b0}} : pinc) | {2'h0, rst_fall[0], 9'h000}};

    wire [5:0] ridx = paddr[7:2];
    reg [31:0] rd_val;
    reg rd_hit;
    always @* begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        case (ridx)
            `EBM_REG_CTRL: rd_val = ctrl_r;
            `EBM_REG_STATUS: rd_val = {15'h0000, np_arm_r, ovf_r, lvl_r, fired_r, alm_r, frq_r, io_r};
            `EBM_REG_SMATCH: rd_val = smatch_r;
            `EBM_REG_ADV: rd_val = adv_r;
            `EBM_REG_ADVCMD: rd_val = advcmd_r;
            `EBM_REG_FILT0: rd_val = filt0_r;
            `EBM_REG_FILT1: rd_val = filt1_r;
            `EBM_REG_DIODIR: rd_val = diodir_r;
            `EBM_REG_DIOMODE: rd_val = diomode_r;
            `EBM_REG_STATSEL: rd_val = {27'h0000000, statsel_r};
            `EBM_REG_STATDAT: rd_val = {16'h0000, cnt_r[statsel_r]};
            default: begin
                if (ridx[5:2] == 4'h3) begin
                    rd_val = chcap_r[ridx[1:0]];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end
    wire wr = psel & penable & pready_r & pwrite & rd_hit;

    always @(posedge clk) begin
        meta_r <= in_bus;
        sync_r <= meta_r;
        prev_r <= sync_r;
        if (reset) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
            ctrl_r <= `EBM_CTRL_RST;
            smatch_r <= 32'h00000000;
            adv_r <= 32'h00000000;
            advcmd_r <= 32'h00000000;
            filt0_r <= 32'h00000000;
            filt1_r <= 32'h00000000;
            diodir_r <= 32'h00000000;
            diomode_r <= 32'h00000000;
            statsel_r <= 5'h00;
            ph_r <= ST_IDLE;
            {nb_r, rn_r, bc_r, tc_r} <= 14'h0000;
            {sh_r, crc_r, op_r, rsp_op_r, cpl_r, rlast_r, rprev_r} <= 56'h0;
            addr_r <= 16'h0000;
            cfg_r <= 32'h00000000;
            {cmd_ok_r, slv_r, fired_r, ovf_r, np_arm_r, np_mid_r} <= 6'h00;
            io_r <= {`EBM_IO_SINGLE, `EBM_IO_SINGLE};
            frq_r <= {`EBM_FRQ_20, `EBM_FRQ_20};
            alm_r <= 2'h0;
            lvl_r <= 2'h0;
            tg_r <= {NDIO{1'b0}};
            dio_o_r <= {NDIO{1'b0}};
            dio_oe_n_r <= {NDIO{1'b1}};
            dio_pend_r <= 1'b0;
            dio_pend_val_r <= {NDIO{1'b0}};
            wp_r <= {(BUF_AW+1){1'b0}};
            rp_r <= {(BUF_AW+1){1'b0}};
            pend_r <= 1'b0;
            rec_valid_r <= 1'b0;
            rec_data_r <= 32'h00000000;
            for (k = 0; k < 4; k = k + 1) begin
                chcap_r[k] <= 32'h00000000;
            end
            for (k = 0; k < 2*`EBM_NCNT; k = k + 1) begin
                cnt_r[k] <= 16'h0000;
            end
        end else begin
            // APB: answer in the first access cycle.
            pready_r <= psel & ~penable;
            pslverr_r <= psel & ~penable & ~rd_hit;
            prdata_r <= (psel & ~penable & ~pwrite) ? rd_val : 32'h00000000;
            if (wr) begin
                case (ridx)
                    `EBM_REG_CTRL: ctrl_r <= pwdata;
                    `EBM_REG_SMATCH: smatch_r <= pwdata;
                    `EBM_REG_ADV: adv_r <= pwdata;
                    `EBM_REG_ADVCMD: advcmd_r <= pwdata;
                    `EBM_REG_FILT0: filt0_r <= pwdata;
                    `EBM_REG_FILT1: filt1_r <= pwdata;
                    `EBM_REG_DIODIR: diodir_r <= pwdata;
                    `EBM_REG_DIOMODE: diomode_r <= pwdata;
                    `EBM_REG_STATSEL: statsel_r <= pwdata[4:0];
                    default: ;
                endcase
            end
            if (cs_fall) begin
                ph_r <= ST_CMD;
                {nb_r, rn_r, bc_r} <= 12'h000;
                crc_r <= 8'h00;
                slv_r <= cs_act[1] & ~cs_act[0];
            end else if (cs_rise) begin
                ph_r <= ST_IDLE;
            end else if (sck_rise) begin
                case (ph_r)
                    ST_CMD: begin
                        sh_r <= sh_nxt;
                        bc_r <= byte_done ? 4'h0 : bc_r + step;
                        if (byte_done && nb_r != 4'h0 && nb_r == cmd_len(op_r)) begin
                            cmd_ok_r <= crc_r == sh_nxt;
                            ph_r <= ST_TAR;
                            tc_r <= 2'h0;
                            crc_r <= 8'h00;
                        end else if (byte_done) begin
                            crc_r <= crc8(crc_r, sh_nxt);
                            nb_r <= nb_r + 4'h1;
                            if (nb_r == 4'h0) begin
                                op_r <= sh_nxt;
                            end else if (nb_r == 4'h1) begin
                                addr_r[15:8] <= sh_nxt;
                            end else if (nb_r == 4'h2) begin
                                addr_r[7:0] <= sh_nxt;
                            end else if (nb_r < 4'h7) begin
                                cfg_r[(nb_r - 4'h3)*8 +: 8] <= sh_nxt;
                            end
                        end
                    end
                    ST_TAR: begin
                        tc_r <= tc_r + 2'h1;
                        if (tc_r == `EBM_TAR_CLKS - 2'h1) begin
                            ph_r <= ST_RSP;
                            bc_r <= 4'h0;
                        end
                    end
                    ST_RSP: begin
                        sh_r <= sh_nxt;
                        bc_r <= byte_done ? 4'h0 : bc_r + step;
                        if (byte_done) begin
                            rn_r <= (rn_r == 4'hF) ? rn_r : rn_r + 4'h1;
                            if (rn_r == 4'h0) begin
                                rsp_op_r <= sh_nxt;
                            end
                            if (rn_r == 4'h1) begin
                                cpl_r <= sh_nxt;
                            end
                            rlast_r <= sh_nxt;
                            rprev_r <= crc_r;
                            crc_r <= crc8(crc_r, sh_nxt);
                        end
                    end
                    default: ph_r <= ST_IDLE;
                endcase
            end
            if (rst_tog) begin
                io_r <= {`EBM_IO_SINGLE, `EBM_IO_SINGLE};
                frq_r <= {`EBM_FRQ_20, `EBM_FRQ_20};
                alm_r <= 2'h0;
            end else if (pkt_end && cmd_ok_r && op_r == `EBM_OP_SET_CFG) begin
                if (addr_r == `EBM_GEN_CAP_ADDR) begin
                    io_r[slv_r*2 +: 2] <= cfg_r[`EBM_GC_IO_LSB +: 2];
                    frq_r[slv_r*3 +: 3] <= cfg_r[`EBM_GC_FRQ_LSB +: 3];
                    alm_r[slv_r] <= cfg_r[`EBM_GC_ALERT_BIT];
                end else if (addr_r[15:7] == 9'h000 && addr_r[3:0] == 4'h0
                             && addr_r[6:4] != 3'h0 && addr_r[6:4] < 3'h5) begin
                    chcap_r[addr_r[5:4] - 2'h1] <= cfg_r;
                end
            end
            if (wr && ridx == `EBM_REG_CTRL) begin
                fired_r <= 1'b0;
                lvl_r <= 2'h0;
                np_arm_r <= 1'b0;
                np_mid_r <= 1'b0;
            end else begin
                if (fire) begin
                    fired_r <= 1'b1;
                end
                if (multi_hit && lvl_r != adv_r[3:2]) begin
                    lvl_r <= lvl_r + 2'h1;
                end
                if (np_req) begin
                    np_arm_r <= 1'b1;
                    np_mid_r <= 1'b0;
                end else if (np_cpl) begin
                    np_mid_r <= np_mid_r | (cpl_r[2:1] == `EBM_CPL_MIDDLE);
                    if (cpl_r[2:1] != `EBM_CPL_MIDDLE && cpl_r[2:1] != `EBM_CPL_FIRST) begin
                        np_arm_r <= 1'b0;
                    end
                end
            end
            // User pins: fixed level or toggle from a chosen start.
            for (k = 0; k < NDIO; k = k + 1) begin
                if (wr && ridx == `EBM_REG_DIOMODE) begin
                    tg_r[k] <= pwdata[2*k] & pwdata[2*k+1];
                end else if (fire && msel_s && smatch_r[21] && smatch_r[20:17] == k) begin
                    tg_r[k] <= ~tg_r[k];
                end else if (a_set && msel_a && adv_r[12] && adv_r[11:8] == k) begin
                    tg_r[k] <= a_val;
                end
                dio_o_r[k] <= diomode_r[2*k+1] ? tg_r[k] : diomode_r[2*k];
            end
            dio_oe_n_r <= ~diodir_r[NDIO-1:0];
            // Input events wait one cycle if a packet record takes the slot.
            if (dio_chg) begin
                dio_pend_r <= 1'b1;
                dio_pend_val_r <= dio_s;
            end else if (dio_wr | ~cap_on) begin
                dio_pend_r <= 1'b0;
            end
            if (we) begin
                wp_r <= wp_r + 1'b1;
            end
            if ((pkt_wr | dio_wr) & full) begin
                ovf_r <= 1'b1;
            end
            if (re) begin
                rp_r <= rp_r + 1'b1;
            end
            pend_r <= re;
            if (pend_r) begin
                rec_valid_r <= 1'b1;
                rec_data_r <= ram_q;
            end else if (rec_ready) begin
                rec_valid_r <= 1'b0;
            end
            for (k = 0; k < 2*`EBM_NCNT; k = k + 1) begin
                if (inc[k]) begin
                    cnt_r[k] <= cnt_r[k] + 16'h0001;
                end
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign user_digital_pin_o = dio_o_r;
    assign user_digital_pin_oe_n = dio_oe_n_r;
    assign rec_valid = rec_valid_r;
    assign rec_data = rec_data_r;
endmodule // ebm_monitor

// file: verif/ebm_props.sv
// Port assertions for the eSPI bus monitor.
`timescale 1ns/1ps
module ebm_props #(parameter NDIO = 11) (
    input wire clk, input wire reset, input wire psel, input wire penable,
    input wire [31:0] prdata, input wire pready, input wire pslverr,
    input wire [NDIO-1:0] user_digital_pin_oe_n,
    input wire rec_valid, input wire [31:0] rec_data, input wire rec_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready");
    a_setup_ans: assert property (psel && !penable |=> pready) else $error("no pready");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata");
    a_rec_hold: assert property (rec_valid & !rec_ready |=> rec_valid & $stable(rec_data))
        else $error("hold");
    a_rec_gap: assert property (rec_valid && rec_ready |=> !rec_valid) else $error("gap");
    a_rec_kind: assert property (rec_valid |-> rec_data[31:28] inside {4'h1, 4'h2})
        else $error("kind");
    a_reset_idle: assert property ($fell(reset) |-> &user_digital_pin_oe_n && !rec_valid)
        else $error("idle");
    c_take: cover property (rec_valid && rec_ready);
    c_err: cover property (pslverr);
    c_drive: cover property (!user_digital_pin_oe_n[0]);
endmodule // ebm_props
bind ebm_monitor ebm_props #(.NDIO(NDIO)) i_ebm_props (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .user_digital_pin_oe_n(user_digital_pin_oe_n), .rec_valid(rec_valid),
    .rec_data(rec_data), .rec_ready(rec_ready));

// file: verif/ebm_bus_model.sv
// Behavioural eSPI master and slave driving the monitored lines.
`timescale 1ns/1ps
module ebm_bus_model (
    output logic espi_sck = 1'b0,
    output logic [1:0] espi_cs_n = 2'b11,
    output logic [3:0] espi_io = 4'hF
);
    function automatic logic [7:0] crc(input logic [7:0] q[$]);
        logic [7:0] x;
        x = 8'h00;
        foreach (q[i]) begin
            x ^= q[i];
            repeat (8) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
        end
        return x;
    endfunction
    // Released lines return to the pull-up level.
    task automatic sh(input logic [7:0] q[$], input int l);
        foreach (q[i]) for (int b = 7; b >= 0; b--) begin
            espi_io[l] = q[i][b];
            #200 espi_sck = 1'b1;
            #200 espi_sck = 1'b0;
        end
        espi_io[l] = 1'b1;
    endtask
    task automatic frame(input logic [7:0] c[$], input logic [7:0] r[$], input bit bad);
        c.push_back(crc(c) ^ {7'h0, bad});
        r.push_back(crc(r));
        #7 espi_cs_n[0] = 1'b0;
        sh(c, 0);
        repeat (2) begin
            #200 espi_sck = 1'b1;
            #200 espi_sck = 1'b0;
        end
        sh(r, 1);
        #400 espi_cs_n[0] = 1'b1;
    endtask
endmodule // ebm_bus_model

// file: verif/tb_ebm_monitor.sv
// Self-checking bench for the eSPI bus monitor.
`timescale 1ns/1ps
module tb_ebm_monitor;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, rec_ready = 1, rst_n = 1, er;
    logic [7:0] paddr = 8'h00;
    logic [10:0] din = 11'h000;
    logic [31:0] pwdata = 32'h0, rd, seed = 32'd85855;
    wire [31:0] prdata, rec_data;
    wire [10:0] dout, doe_n;
    wire [3:0] io;
    wire [1:0] cs_n;
    wire pready, pslverr, rec_valid, sck;
    int n_errors = 0, cmp_count = 0;
    ebm_monitor #(.NDIO(11), .BUF_AW(4)) i_ebm_monitor (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .espi_sck(sck), .espi_cs_n(cs_n), .espi_io(io),
        .alert_pin_first(1'b1), .alert_pin_second(1'b1), .bus_reset_first_n(rst_n),
        .bus_reset_second_n(1'b1), .user_digital_pin_i(din), .user_digital_pin_o(dout),
        .user_digital_pin_oe_n(doe_n), .rec_valid(rec_valid), .rec_data(rec_data),
        .rec_ready(rec_ready));
    ebm_bus_model i_ebm_bus_model (.espi_sck(sck), .espi_cs_n(cs_n), .espi_io(io));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic get_rec(input logic [31:0] exp, input logic [31:0] m);
        do @(posedge clk); while ((rec_valid & rec_ready) !== 1'b1);
        chk(rec_data & m, exp);
    endtask
    task automatic pkt(input bit bad, input logic [31:0] exp);
        i_ebm_bus_model.frame('{8'h25}, '{8'h08}, bad);
        get_rec(exp, '1);
    endtask
    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial forever #25 clk = ~clk;
    initial begin
        #2ms;
        n_errors++;
        report_and_stop();
    end
    always @(posedge clk) rec_ready <= rnd() % 3 != 0;
    initial begin
        logic [10:0] v;
        repeat (16) @(posedge clk);
        reset <= 0;
        apb(0, 8'h04, 0);
        chk(rd & 32'h7F, 0);
        apb(0, 8'h2C, 0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1, 8'h1C, 32'h07F0000F);
        apb(1, 8'h20, 32'hE4);
        apb(1, 8'h00, 32'h1);
        chk({24'h0, dout[3:0], doe_n[3:0]}, 32'hA0);
        repeat (4) begin
            v = din ^ 11'h010 ^ (11'(rnd()) & 11'h7E0);
            din <= v;
            get_rec({4'h2, 17'h0, v}, '1);
        end
        pkt(0, 32'h10302508);
        pkt(1, 32'h10102508);
        apb(1, 8'h24, 0);
        apb(0, 8'h28, 0);
        chk(rd, 1);
        i_ebm_bus_model.frame('{8'h22, 0, 8'h08, 0, 0, 8'h20, 8'h04}, '{8'h08}, 0);
        get_rec(32'h10002208, 32'hF000FFFF);
        apb(0, 8'h04, 0);
        chk(rd & 32'h73, 32'h21);
        rst_n <= 0;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        apb(0, 8'h04, 0);
        chk(rd & 32'h73, 0);
        apb(1, 8'h08, 32'h00240125);
        apb(1, 8'h00, 32'h5);
        repeat (2) pkt(0, 32'h10302508);
        apb(0, 8'h04, 0);
        chk({rd[12], dout[2]}, 2'b11);
        apb(1, 8'h14, 32'h225);
        i_ebm_bus_model.frame('{8'h21, 0, 8'h08}, '{8'h08}, 0);
        apb(1, 8'h24, 32'hB);
        apb(0, 8'h28, 0);
        chk(rd, 1);
        apb(1, 8'h00, 32'h3);
        i_ebm_bus_model.frame('{8'h25}, '{8'h08}, 0);
        repeat (9) @(posedge clk);
        chk(rec_valid, 0);
        apb(1, 8'h00, 0);
        get_rec(32'h10302508, '1);
        report_and_stop();
    end
endmodule // tb_ebm_monitor
